// *** hw/sll_tx_link.sv ***
// transmit link layer: 8b/10b alignment and 64b/66b block framing
//
// Operation
// - sync request low: send K28.5 continuously
// - after sync rise, start alignment at multiframe edge
// - four multiframes, R first, A last, config second
// - unscrambled repeated frame-final octet becomes K28.7
// - repeated octet in multiframe end becomes K28.3
// - scrambled frame-final 0xFC sent as K28.7
// - scrambled multiframe-final 0x7C sent as K28.3
// - 64b mode: scramble 8-octet block, prefix header
// - header bits 0-1, octet n at 2+8n
// - 32 blocks per multiblock, E per extended
// - extended multiblock clock phase reset by SYSREF
// - header bits differ: 10 is one, 01 zero
// - headers of 32 blocks form stream word
// - stream word ends 00001, unique in CRC mode
// - bit 22 set only in last multiblock
// - only CRC-12 and FEC stream contents
// - alignment sequence unscrambled; 64b always scrambled
// - multiframe clock reset by SYSREF, F*K octets
module sll_tx_link
  import sll_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic                  sync_n_pin,
  input  wire logic                  sysref_pin,
  input  wire sll_cfg_t              cfg,
  input  wire logic [ILAS_CFG_W-1:0] ilas_cfg,
  input  wire logic [11:0]           crc_par,
  input  wire logic [25:0]           fec_par,
  input  wire logic [BLK_DATA_W-1:0] tx_data,
  output logic                       tx_ready,
  output sll_char_t                  char_out,
  output logic [BLK_W-1:0]           blk_out,
  output logic                       link_up,
  output logic                       lmfc_edge,
  output logic                       lemc_edge
);

  // builds the 32-bit sync header stream word, bit n rides on block n
  function automatic logic [31:0] shs_word(
    input logic [11:0] c,
    input logic [25:0] f,
    input logic        fec,
    input logic        eoemb
  );
    logic [31:0] w;
    w = fec ? SHS_PILOT_FEC : SHS_PILOT_CRC;
    if (fec) begin
      for (int i = 0; i < 22; i++) begin
        w[i] = f[25-i];
      end
      for (int i = 23; i < 27; i++) begin
        w[i] = f[26-i];
      end
    end else begin
      for (int g = 0; g < 4; g++) begin
        for (int j = 0; j < 3; j++) begin
          w[4*g+j] = c[11-3*g-j];
        end
      end
    end
    w[EOEMB_BIT] = eoemb;
    return w;
  endfunction

  logic                  sync_s1_reg;
  logic                  sync_s2_reg;
  logic                  sysref_s1_reg;
  logic                  sysref_s2_reg;
  logic                  sysref_s3_reg;
  logic                  sysref_rise;
  logic [7:0]            oct_cnt_reg;
  logic [7:0]            frm_cnt_reg;
  logic [15:0]           mf_pos_reg;
  logic                  oct_last;
  logic                  frm_last;
  logic                  mf_last;
  logic                  mf_first;
  sll_state_t            state_reg;
  logic [1:0]            ilas_mf_reg;
  logic [7:0]            prev_oct_reg;
  logic                  prev_vld_reg;
  sll_char_t             char_next;
  logic [7:0]            cur_oct;
  logic [7:0]            cfg_oct;
  logic [4:0]            blk_cnt_reg;
  logic [7:0]            emb_cnt_reg;
  logic                  emb_last;
  logic [11:0]           crc_reg;
  logic [25:0]           fec_reg;
  logic [31:0]           shs_cur;
  logic [SCR_LEN-1:0]    scr_reg;
  logic [SCR_LEN-1:0]    scr_next;
  logic [BLK_DATA_W-1:0] scr_out;

  // two flops on sync, three on sysref; sysref edge detection compares the second and third
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync_s1_reg   <= 1'b0;
      sync_s2_reg   <= 1'b0;
      sysref_s1_reg <= 1'b0;
      sysref_s2_reg <= 1'b0;
      sysref_s3_reg <= 1'b0;
    end else begin
      sync_s1_reg   <= sync_n_pin;
      sync_s2_reg   <= sync_s1_reg;
      sysref_s1_reg <= sysref_pin;
      sysref_s2_reg <= sysref_s1_reg;
      sysref_s3_reg <= sysref_s2_reg;
    end
  end

  assign sysref_rise = sysref_s2_reg & ~sysref_s3_reg;

  // multiframe clock: one octet per cycle, F*K octets per multiframe
  assign oct_last = (oct_cnt_reg == cfg.f_m1);
  assign frm_last = (frm_cnt_reg == cfg.k_m1);
  assign mf_last  = oct_last & frm_last;
  assign mf_first = (mf_pos_reg == '0);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oct_cnt_reg <= '0;
      frm_cnt_reg <= '0;
      mf_pos_reg  <= '0;
    end else if (sysref_rise) begin
      oct_cnt_reg <= '0;
      frm_cnt_reg <= '0;
      mf_pos_reg  <= '0;
    end else if (oct_last) begin
      oct_cnt_reg <= '0;
      frm_cnt_reg <= frm_last ? '0 : frm_cnt_reg + 8'h01;
      mf_pos_reg  <= frm_last ? '0 : mf_pos_reg + 16'h0001;
    end else begin
      oct_cnt_reg <= oct_cnt_reg + 8'h01;
      mf_pos_reg  <= mf_pos_reg + 16'h0001;
    end
  end

  assign lmfc_edge = mf_first;

  // link start-up; a low sync request pulls back to comma stream
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= ST_CGS;
      ilas_mf_reg <= '0;
    end else if (!sync_s2_reg || cfg.mode_64b) begin
      state_reg   <= ST_CGS;
      ilas_mf_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_CGS: begin
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          // next cycle is the multiframe edge
          if (mf_last && !sysref_rise) begin
            state_reg   <= ST_ILAS;
            ilas_mf_reg <= '0;
          end
        end
        ST_ILAS: begin
          // a sysref mid-sequence would break the count; restart
          if (sysref_rise) begin
            state_reg <= ST_WAIT;
          end else if (mf_last) begin
            if (ilas_mf_reg == ILAS_MF_LAST) begin
              state_reg <= ST_DATA;
            end else begin
              ilas_mf_reg <= ilas_mf_reg + 2'h1;
            end
          end
        end
        ST_DATA: begin
          state_reg <= ST_DATA;
        end
      endcase
    end
  end

  // config octets ride in the second multiframe after its R character
  always_comb begin
    cfg_oct = '0;
    for (int i = 0; i < ILAS_CFG_OCTS; i++) begin
      if (mf_pos_reg == ILAS_CFG_FIRST + 16'(i)) begin
        cfg_oct = ilas_cfg[8*i +: 8];
      end
    end
  end

  assign cur_oct = tx_data[7:0];

  // 8b/10b character selection, ahead of the encoder
  always_comb begin
    char_next.is_k = 1'b1;
    char_next.code = K28_5_CODE;
    unique case (state_reg)
      ST_CGS, ST_WAIT: begin
        char_next.is_k = 1'b1;
        char_next.code = K28_5_CODE;
      end
      ST_ILAS: begin
        // sent as is: the sequence never passes the scrambler
        char_next.is_k = 1'b0;
        char_next.code = mf_pos_reg[7:0];
        if (mf_first) begin
          char_next.is_k = 1'b1;
          char_next.code = K28_0_CODE;
        end else if (mf_last) begin
          char_next.is_k = 1'b1;
          char_next.code = K28_3_CODE;
        end else if (ilas_mf_reg == ILAS_MF_CFG &&
                     mf_pos_reg <= ILAS_CFG_LAST) begin
          char_next.code = cfg_oct;
        end
      end
      ST_DATA: begin
        char_next.is_k = 1'b0;
        char_next.code = cur_oct;
        if (oct_last && cfg.scr_en) begin
          if (mf_last && cur_oct == SCR_MF_OCT) begin
            char_next.is_k = 1'b1;
            char_next.code = K28_3_CODE;
          end else if (cur_oct == SCR_FRAME_OCT) begin
            char_next.is_k = 1'b1;
            char_next.code = K28_7_CODE;
          end
        end else if (oct_last && prev_vld_reg &&
                     cur_oct == prev_oct_reg) begin
          char_next.is_k = 1'b1;
          char_next.code = mf_last ? K28_3_CODE
                                   : K28_7_CODE;
        end
      end
      default: begin
        char_next.is_k = 1'b1;
        char_next.code = K28_5_CODE;
      end
    endcase
  end

  // last octet of the previous frame, as data, for repeat detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prev_oct_reg <= '0;
      prev_vld_reg <= 1'b0;
    end else if (state_reg != ST_DATA) begin
      prev_vld_reg <= 1'b0;
    end else if (oct_last) begin
      prev_oct_reg <= cur_oct;
      prev_vld_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      char_out.is_k <= 1'b1;
      char_out.code <= K28_5_CODE;
    end else begin
      char_out <= char_next;
    end
  end

  // extended multiblock clock: one block per cycle in 64b mode
  assign emb_last = (emb_cnt_reg == cfg.e_m1);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      blk_cnt_reg <= '0;
      emb_cnt_reg <= '0;
    end else if (sysref_rise) begin
      blk_cnt_reg <= '0;
      emb_cnt_reg <= '0;
    end else if (blk_cnt_reg == MB_BLK_LAST) begin
      blk_cnt_reg <= '0;
      emb_cnt_reg <= emb_last ? '0 : emb_cnt_reg + 8'h01;
    end else begin
      blk_cnt_reg <= blk_cnt_reg + 5'h01;
    end
  end

  assign lemc_edge = (blk_cnt_reg == '0) && (emb_cnt_reg == '0);

  // parity of a multiblock goes out in the stream of the next one
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      crc_reg <= '0;
      fec_reg <= '0;
    end else if (blk_cnt_reg == MB_BLK_LAST) begin
      crc_reg <= crc_par;
      fec_reg <= fec_par;
    end
  end

  // only the CRC-12 and FEC layouts exist here
  assign shs_cur = shs_word(crc_reg, fec_reg, cfg.fec_mode,
                            emb_last);

  // self-synchronous scrambler over the 64 payload bits
  always_comb begin
    scr_next = scr_reg;
    scr_out  = '0;
    for (int i = 0; i < BLK_DATA_W; i++) begin
      scr_out[i] = tx_data[i] ^ scr_next[SCR_TAP_A]
                              ^ scr_next[SCR_TAP_B];
      scr_next = {scr_next[SCR_LEN-2:0], scr_out[i]};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scr_reg <= SCR_SEED;
    end else if (cfg.mode_64b) begin
      scr_reg <= scr_next;
    end
  end

  // header in bits 0-1, octet n in bits 2+8n; stream bit per block
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      blk_out <= BLK_RST;
    end else if (cfg.mode_64b) begin
      blk_out <= {scr_out,
                  shs_cur[blk_cnt_reg] ? SH_ONE : SH_ZERO};
    end
  end

  // a 64b block is taken every cycle; 8b data only once aligned
  assign tx_ready = cfg.mode_64b | (state_reg == ST_DATA);
  assign link_up  = tx_ready;

endmodule

// *** pkg/sll_pkg.sv ***
// constants and carrier types for the serial link transmit layer
package sll_pkg;

  // 8b/10b control characters, by their octet value with the k flag set
  localparam logic [7:0] K28_0_CODE     = 8'h1C;
  localparam logic [7:0] K28_3_CODE     = 8'h7C;
  localparam logic [7:0] K28_5_CODE     = 8'hBC;
  localparam logic [7:0] K28_7_CODE     = 8'hFC;
  // scrambled-mode octets that are carried as alignment characters
  localparam logic [7:0] SCR_FRAME_OCT  = 8'hFC;
  localparam logic [7:0] SCR_MF_OCT     = 8'h7C;

  // initial lane alignment sequence
  localparam logic [1:0] ILAS_MF_LAST   = 2'h3;
  localparam logic [1:0] ILAS_MF_CFG    = 2'h1;
  localparam int         ILAS_CFG_OCTS  = 14;
  localparam int         ILAS_CFG_W     = ILAS_CFG_OCTS * 8;
  localparam logic [15:0] ILAS_CFG_FIRST = 16'h0001;
  localparam logic [15:0] ILAS_CFG_LAST  = 16'h000E;

  // 64b/66b block and multiblock structure
  localparam int         BLK_DATA_W     = 64;
  localparam int         BLK_W          = 66;
  localparam logic [4:0] MB_BLK_LAST    = 5'h1F;
  localparam logic [1:0] SH_ONE         = 2'h2;
  localparam logic [1:0] SH_ZERO        = 2'h1;
  localparam logic [BLK_W-1:0] BLK_RST  = {{BLK_DATA_W{1'b0}}, SH_ZERO};

  // sync header stream layout
  localparam int          EOEMB_BIT     = 22;
  localparam logic [31:0] SHS_PILOT_CRC = 32'h80A8_8888;
  localparam logic [31:0] SHS_PILOT_FEC = 32'h8000_0000;

  // self-synchronous scrambler state and taps
  localparam int          SCR_LEN       = 58;
  localparam int          SCR_TAP_A     = 38;
  localparam int          SCR_TAP_B     = 57;
  localparam logic [SCR_LEN-1:0] SCR_SEED = {SCR_LEN{1'b1}};

  typedef enum logic [3:0] {
    ST_CGS  = 4'h1,
    ST_WAIT = 4'h2,
    ST_ILAS = 4'h4,
    ST_DATA = 4'h8
  } sll_state_t;

  // static link configuration, held steady while the link runs
  typedef struct packed {
    logic       mode_64b;
    logic       scr_en;
    logic       fec_mode;
    logic [7:0] f_m1;
    logic [7:0] k_m1;
    logic [7:0] e_m1;
  } sll_cfg_t;

  typedef struct packed {
    logic       is_k;
    logic [7:0] code;
  } sll_char_t;

endpackage

// *** bench/sll_tx_link_chk.sv ***
// port assertions for the transmit link layer
module sll_tx_link_chk
  import sll_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        sync_n_pin,
  input wire logic        sysref_pin,
  input wire sll_cfg_t    cfg,
  input wire logic [63:0] tx_data,
  input wire logic        link_up,
  input wire sll_char_t   char_out,
  input wire logic [65:0] blk_out,
  input wire logic        lmfc_edge,
  input wire logic        lemc_edge
);
  logic [7:0]      oct_reg;
  logic [7:0]      frm_reg;
  logic [7:0]      last_reg;
  logic            vld_reg;
  wire logic [7:0] oct = lmfc_edge ? 8'h00 : oct_reg;
  wire logic [7:0] frm = lmfc_edge ? 8'h00 : frm_reg;
  wire logic       fl  = oct == cfg.f_m1;
  wire logic       mfl = fl && frm == cfg.k_m1;
  wire logic       d8  = link_up && !cfg.mode_64b;
  wire logic [7:0] dat = tx_data[7:0];
  // frame position rebuilt from the multiframe marker alone
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oct_reg <= 8'h00;
      frm_reg <= 8'h00;
    end else begin
      oct_reg <= fl ? 8'h00 : oct + 8'h01;
      frm_reg <= fl ? frm + 8'h01 : frm;
    end
  end
  // first data frame has no predecessor to repeat
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_reg <= 8'h00;
      vld_reg  <= 1'b0;
    end else if (!d8) begin
      vld_reg <= 1'b0;
    end else if (fl) begin
      last_reg <= dat;
      vld_reg  <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_comma;
    (!cfg.mode_64b && !sync_n_pin) [*4]
      |=> char_out == {1'b1, K28_5_CODE};
  endproperty
  a_comma: assert property (p_comma) else $error("no comma");
  property p_start;
    !cfg.mode_64b && char_out == {1'b1, K28_0_CODE} |-> $past(lmfc_edge);
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_align;
    !cfg.mode_64b && char_out == {1'b1, K28_3_CODE} |-> lmfc_edge;
  endproperty
  a_align: assert property (p_align) else $error("bad /A/");
  property p_rep;
    d8 && !cfg.scr_en && fl && vld_reg && dat == last_reg
      |=> char_out.is_k && char_out.code ==
          ($past(mfl) ? K28_3_CODE : K28_7_CODE);
  endproperty
  a_rep: assert property (p_rep) else $error("no repeat mark");
  property p_scr7;
    d8 && cfg.scr_en && fl && dat == SCR_FRAME_OCT
      |=> char_out == {1'b1, K28_7_CODE};
  endproperty
  a_scr7: assert property (p_scr7) else $error("no /F/");
  property p_scr3;
    d8 && cfg.scr_en && mfl && dat == SCR_MF_OCT
      |=> char_out == {1'b1, K28_3_CODE};
  endproperty
  a_scr3: assert property (p_scr3) else $error("no /A/");
  property p_sh;
    cfg.mode_64b |=> blk_out[1] != blk_out[0];
  endproperty
  a_sh: assert property (p_sh) else $error("bad header");
  // a phase reset cuts the window short, so sysref aborts it
  property p_pilot;
    disable iff (!rstn || sysref_pin)
    cfg.mode_64b && lemc_edge |-> ##28 (blk_out[1:0] == SH_ZERO) [*4]
      ##1 blk_out[1:0] == SH_ONE;
  endproperty
  a_pilot: assert property (p_pilot) else $error("bad pilot");
  property p_eoemb;
    disable iff (!rstn || sysref_pin)
    cfg.mode_64b && cfg.e_m1 == 8'h01 && lemc_edge
      |-> ##23 blk_out[1:0] == SH_ZERO ##32 blk_out[1:0] == SH_ONE;
  endproperty
  a_eoemb: assert property (p_eoemb) else $error("bad eoemb");
  property p_sref;
    $rose(sysref_pin) |-> ##3 (cfg.mode_64b ? lemc_edge : lmfc_edge);
  endproperty
  a_sref: assert property (p_sref) else $error("no reset");
endmodule
bind sll_tx_link sll_tx_link_chk chk (
  .mclk       (mclk),
  .rstn       (rstn),
  .sync_n_pin (sync_n_pin),
  .sysref_pin (sysref_pin),
  .cfg        (cfg),
  .tx_data    (tx_data),
  .link_up    (link_up),
  .char_out   (char_out),
  .blk_out    (blk_out),
  .lmfc_edge  (lmfc_edge),
  .lemc_edge  (lemc_edge)
);

// *** bench/sll_rx_model.sv ***
// receiver model: releases the sync request after four commas
module sll_rx_model
  import sll_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire sll_cfg_t         cfg,
  input  wire sll_char_t        char_out,
  input  wire logic [BLK_W-1:0] blk_out,
  input  wire logic             lmfc_edge,
  input  wire logic             drop,
  output logic                  sync_n,
  output logic [7:0]            rx_oct,
  output logic                  hdr_bad
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] run_reg;
  logic       mf_d_reg;
  logic [7:0] pos_reg;
  logic [7:0] fin_reg;
  logic [7:0] pos;
  logic [7:0] oct;
  logic       is_mark;
  // the character lags the multiframe marker by one cycle
  assign pos     = mf_d_reg ? 8'h00 : pos_reg;
  assign is_mark = char_out.is_k && (char_out.code == K28_7_CODE ||
                                     char_out.code == K28_3_CODE);
  always_comb begin
    oct = char_out.code;
    if (is_mark && cfg.scr_en) begin
      oct = char_out.code == K28_7_CODE ? SCR_FRAME_OCT
                                        : SCR_MF_OCT;
    end else if (is_mark && pos == cfg.f_m1) begin
      oct = fin_reg;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mf_d_reg <= 1'b0;
      pos_reg  <= 8'h00;
      fin_reg  <= 8'h00;
      rx_oct   <= 8'h00;
    end else begin
      mf_d_reg <= lmfc_edge;
      pos_reg  <= pos == cfg.f_m1 ? 8'h00 : pos + 8'h01;
      rx_oct   <= oct;
      if (pos == cfg.f_m1) begin
        fin_reg <= oct;
      end
    end
  end
  // a real receiver would slip on 00 or 11; here the event is kept
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hdr_bad <= 1'b0;
    end else if (cfg.mode_64b && blk_out[1] == blk_out[0]) begin
      hdr_bad <= 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      run_reg <= 3'h0;
      sync_n  <= 1'b0;
    end else if (drop) begin
      run_reg <= 3'h0;
      sync_n  <= 1'b0;
    end else begin
      if (run_reg != 3'h4) begin
        run_reg <= char_out == {1'b1, K28_5_CODE} ? run_reg + 3'h1 : 3'h0;
      end
      if (run_reg == 3'h4 && lmfc_edge) begin
        sync_n <= 1'b1;
      end
    end
  end
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the transmit link layer
module tb_top
  import sll_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  mclk       = 1'b0;
  logic                  rstn       = 1'b0;
  logic                  sysref_pin = 1'b0;
  logic                  drop       = 1'b0;
  logic                  sync_n_pin;
  sll_cfg_t              cfg        = {3'b000, 8'h03, 8'h03, 8'h01};
  logic [ILAS_CFG_W-1:0] ilas_cfg   = 112'hF1E2D3C4B5A6978879605A4B3C2D;
  logic [11:0]           crc_par    = 12'hA5C;
  logic [25:0]           fec_par    = 26'h2B4C1E5;
  logic [63:0]           tx_data    = 64'h55;
  logic                  tx_ready;
  logic                  link_up;
  logic                  lmfc_edge;
  logic                  lemc_edge;
  sll_char_t             char_out;
  logic [7:0]            rx_oct;
  logic                  hdr_bad;
  logic [BLK_W-1:0]      blk_out;
  int                    bad_count  = 0;
  int                    tests_run  = 0;
  int                    cyc        = 0;
  always #2.5 mclk = ~mclk;
  sll_rx_model rx (
    .mclk      (mclk),
    .rstn      (rstn),
    .cfg       (cfg),
    .char_out  (char_out),
    .blk_out   (blk_out),
    .lmfc_edge (lmfc_edge),
    .drop      (drop),
    .sync_n    (sync_n_pin),
    .rx_oct    (rx_oct),
    .hdr_bad   (hdr_bad)
  );
  sll_tx_link uut (
    .mclk       (mclk),
    .rstn       (rstn),
    .sync_n_pin (sync_n_pin),
    .sysref_pin (sysref_pin),
    .cfg        (cfg),
    .ilas_cfg   (ilas_cfg),
    .crc_par    (crc_par),
    .fec_par    (fec_par),
    .tx_data    (tx_data),
    .tx_ready   (tx_ready),
    .char_out   (char_out),
    .blk_out    (blk_out),
    .link_up    (link_up),
    .lmfc_edge  (lmfc_edge),
    .lemc_edge  (lemc_edge)
  );
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // the run is far shorter than this; a hang lands here
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [65:0] seen, input logic [65:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic t_cgs;
    drop = 1'b1;
    tick(6);
    check(char_out, {1'b1, K28_5_CODE});
    check(link_up, 1'b0);
    sysref_pin = 1'b1;
    tick(4);
    sysref_pin = 1'b0;
    drop = 1'b0;
    $display("cgs done");
  endtask
  task automatic t_ilas;
    int i;
    int p;
    logic [8:0] e;
    for (i = 0; i < 400 && char_out !== {1'b1, K28_0_CODE}; i++) tick(1);
    for (i = 0; i < 64; i++) begin
      p = i % 16;
      e = {1'b0, 4'h0, p[3:0]};
      if (i / 16 == 1 && p > 0 && p < 15) e = {1'b0, ilas_cfg[8*(p-1) +: 8]};
      if (p == 0) e = {1'b1, K28_0_CODE};
      if (p == 15) e = {1'b1, K28_3_CODE};
      check(char_out, e);
      if (i < 63) tick(1);
    end
    check(link_up, 1'b1);
    $display("ilas done");
  endtask
  task automatic t_mon;
    logic [7:0] dt [3] = '{8'h55, 8'hFC, 8'h7C};
    int e7 [3] = '{12, 16, 0};
    int e3 [3] = '{4, 0, 4};
    int i;
    int k7;
    int k3;
    for (i = 0; i < 3; i++) begin
      cfg.scr_en = i > 0;
      tx_data = {56'h0, dt[i]};
      tick(20);
      k7 = 0;
      k3 = 0;
      repeat (64) begin
        tick(1);
        check(rx_oct, dt[i]);
        if (char_out === {1'b1, K28_7_CODE}) k7++;
        if (char_out === {1'b1, K28_3_CODE}) k3++;
      end
      check(k7, e7[i]);
      check(k3, e3[i]);
    end
    $display("monitoring done");
  endtask
  function automatic logic [31:0] exp_word(input logic eo);
    logic [31:0] w;
    int i;
    if (cfg.fec_mode) begin
      w = 32'h8000_0000;
      for (i = 0; i < 22; i++) w[i] = fec_par[25 - i];
      for (i = 0; i < 4; i++) w[23 + i] = fec_par[3 - i];
    end else begin
      w = 32'h80A8_8888;
      for (i = 0; i < 12; i++) w[i + i / 3] = crc_par[11 - i];
    end
    w[22] = eo;
    return w;
  endfunction
  task automatic t_64b;
    int m;
    int n;
    logic [31:0] w;
    logic [127:0] s;
    logic [63:0] e;
    cfg.mode_64b = 1'b1;
    tick(1);
    check(tx_ready, 1'b1);
    sysref_pin = 1'b1;
    tick(4);
    sysref_pin = 1'b0;
    for (m = 0; m < 2; m++) begin
      cfg.fec_mode = m[0];
      tick(70);
      for (n = 0; n < 200 && lemc_edge !== 1'b1; n++) tick(1);
      for (n = 0; n < 64; n++) begin
        tick(1);
        // one sysref pulse per pass, landing on the extended multiblock edge, keeps phase
        sysref_pin = n == 60;
        w[n % 32] = blk_out[1:0] === SH_ONE;
        if (n % 32 == 31) check(w, exp_word(n > 31));
      end
    end
    check(blk_out[65:2] !== 64'h0, 1'b1);
    // self-synchronous: each bit from the two taps of the sent stream
    s[63:0] = blk_out[65:2];
    tick(1);
    s[127:64] = blk_out[65:2];
    for (n = 0; n < 64; n++) begin
      e[n] = tx_data[n] ^ s[63+n-SCR_TAP_A] ^ s[63+n-SCR_TAP_B];
    end
    check(blk_out[65:2], e);
    check(hdr_bad, 1'b0);
    $display("blocks done");
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    rstn = 1'b1;
    t_cgs();
    t_ilas();
    t_mon();
    t_cgs();
    t_ilas();
    t_64b();
    give_verdict();
  end
endmodule
